// >>> rtl/lmi_pkg.sv
// How it works
// [RULE_01] Initialize-mode opcode 99 is invalid unless diagnose 83 came right before.
// [RULE_02] Initialize-mode copies 512 bytes from main storage at its operand into aux storage.
// [RULE_03] Load method field: 0 none, 1 first card, 2 tape, 9 second card.
// [RULE_04] Card load clears emulated positions 001-080, then word-marks position 001.
// [RULE_05] Invalid character 8F goes to the byte just below emulated address zero.
// [RULE_06] Last step sets the compatibility mode bit; it selects the compatibility store.
// [RULE_07] Execution starts at the saved two-byte instruction counter from aux storage.
// [RULE_08] Memory wrap flags only on access or address store, never on increment alone.
// [RULE_09] Last-card indicator clears on start reset or the first read after it.
// [RULE_10] Channel 9 and 12 indicators clear on next printer command, not on punches.
// [RULE_11] After reflective strip, every write to that unit reports end-of-file until rewind/backspace.
// [RULE_12] A tape mark read in odd redundancy leaves the tape error indicator alone.
// [RULE_13] With check-stop on, a second reader read error halts at end of card.
// [RULE_14] Column binary: invalid characters entering positions 001-080 are stored as blank.
// [RULE_15] Any system reset clears the compatibility mode bit.
// [RULE_16] The diagnose enable is consumed by the very next instruction.
package lmi_pkg;
   // ==========================================================
   // Opcodes and load methods.
   localparam logic [7:0] OP_DIAGNOSE = 8'h83;
   localparam logic [7:0] OP_INIT_MODE = 8'h99;
   localparam logic [3:0] LM_NONE = 4'h0;
   localparam logic [3:0] LM_CARD1 = 4'h1;
   localparam logic [3:0] LM_TAPE = 4'h2;
   localparam logic [3:0] LM_CARD2 = 4'h9;
   // ==========================================================
   // Auxiliary storage layout.
   localparam logic [9:0] AUX_BYTES = 10'h0200;
   localparam logic [8:0] AUX_IC_HI = 9'h009c;
   localparam logic [8:0] AUX_IC_LO = 9'h009d;
   localparam logic [8:0] AUX_BIAS_HI = 9'h009e;
   localparam logic [8:0] AUX_BIAS_LO = 9'h009f;
   // ==========================================================
   // Character codes and emulated positions.
   localparam logic [7:0] CH_BLANK = 8'h40;
   localparam logic [7:0] CH_BLANK_WM = 8'h00;
   localparam logic [7:0] CH_GUARD = 8'h8f;
   localparam logic [9:0] POS_FIRST = 10'h0001;
   localparam logic [9:0] POS_LAST = 10'h0050;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam int TAPE_UNITS = 8;
   // ==========================================================
   // Initialization sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE, ST_COPY, ST_AUX_RD, ST_CLEAR, ST_WMARK, ST_GUARD, ST_FINISH
   } lmi_state_t;
endpackage

// >>> rtl/lmi_aux_mem.sv
`timescale 1ns/10ps
module lmi_aux_mem
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [8:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [8:0] rd_addr,
   output logic [7:0] rd_data
);
   typedef struct packed {
      logic [511:0][7:0] mem;
      logic [7:0] rdata;
   } lmi_aux_t;

   lmi_aux_t cur_ff;
   lmi_aux_t nxt_cur;

   // ==========================================================
   // Write port and registered read port.
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.rdata = cur_ff.mem[rd_addr];
      if (wr_en)
      begin
         nxt_cur.mem[wr_addr] = wr_data;
      end
   end

   // Storage update.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign rd_data = cur_ff.rdata;
endmodule

// >>> rtl/lmi_core.sv
`timescale 1ns/10ps
module lmi_core
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sys_reset,
   input wire logic instr_valid,
   input wire logic [7:0] instr_opcode,
   input wire logic [15:0] instr_operand_addr,
   input wire logic [3:0] load_method_field,
   output logic mem_req_ff,
   output logic mem_we_ff,
   output logic [15:0] mem_addr_ff,
   output logic [7:0] mem_wdata_ff,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic init_busy_ff,
   output logic invalid_op_ff,
   output logic start_exec_ff,
   output logic [15:0] instr_counter_pair_ff,
   output logic compat_mode_bit_ff,
   input wire logic addr_past_size,
   input wire logic addr_access,
   input wire logic addr_store_sar,
   input wire logic wrap_clear,
   output logic wrap_ind_ff,
   input wire logic last_card_evt,
   input wire logic start_reset,
   input wire logic read_instr,
   output logic last_card_ind_ff,
   input wire logic ch9_sense,
   input wire logic ch12_sense,
   input wire logic printer_cmd,
   output logic ch9_ind_ff,
   output logic ch12_ind_ff,
   input wire logic [2:0] tape_unit,
   input wire logic tape_strip_evt,
   input wire logic tape_write,
   input wire logic tape_rewind,
   input wire logic tape_backspace,
   output logic tape_eof_ind_ff,
   input wire logic tape_err_evt,
   input wire logic tape_mark_read,
   input wire logic tape_odd_redund,
   input wire logic tape_err_clear,
   output logic tape_err_ind_ff,
   input wire logic check_stop_sw,
   input wire logic rdr2_read_err,
   input wire logic rdr2_card_end,
   output logic rdr2_halt_ff,
   input wire logic cb_mode,
   input wire logic cb_valid,
   input wire logic [7:0] cb_char,
   input wire logic cb_char_legal,
   input wire logic [9:0] cb_pos,
   output logic cb_store_ff,
   output logic [7:0] cb_char_out_ff
);
   typedef struct packed {
      lmi_pkg::lmi_state_t st;
      logic [9:0] idx;
      logic diag_en;
      logic [15:0] base;
      logic [3:0] method;
      logic [15:0] bias;
      logic aux_we;
      logic [8:0] aux_waddr;
      logic [7:0] aux_wdata;
      logic [8:0] aux_raddr;
      logic [lmi_pkg::TAPE_UNITS-1:0] eof_armed;
      logic cs_meta;
      logic cs_sync;
      logic err_seen;
   } lmi_core_t;

   lmi_core_t cur_ff;
   lmi_core_t nxt_cur;
   logic [7:0] aux_rdata;
   logic [lmi_pkg::TAPE_UNITS-1:0] nxt_armed;
   logic nxt_req, nxt_we, nxt_busy, nxt_inv, nxt_start, nxt_compat, nxt_wrap, nxt_last;
   logic nxt_ch9, nxt_ch12, nxt_eof, nxt_terr, nxt_halt, nxt_cbs;
   logic [15:0] nxt_addr, nxt_ic;
   logic [7:0] nxt_wdata, nxt_cbc;
   logic card_load;

   assign card_load = (cur_ff.method == lmi_pkg::LM_CARD1) ||
                      (cur_ff.method == lmi_pkg::LM_CARD2); // see [RULE_03]

   lmi_aux_mem u_aux
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .wr_en(cur_ff.aux_we),
      .wr_addr(cur_ff.aux_waddr),
      .wr_data(cur_ff.aux_wdata),
      .rd_addr(cur_ff.aux_raddr),
      .rd_data(aux_rdata)
   );

   // ==========================================================
   // Per-unit end-of-file arming.
   genvar gu;
   generate
      for (gu = 0; gu < lmi_pkg::TAPE_UNITS; gu++)
      begin : g_unit
         // Strip arms the unit; its own rewind or backspace disarms it.
         assign nxt_armed[gu] = (tape_unit == 3'(gu) && tape_strip_evt) ||
            (cur_ff.eof_armed[gu] &&
             !(tape_unit == 3'(gu) && (tape_rewind || tape_backspace))); // see [RULE_11]
      end
   endgenerate

   // ==========================================================
   // Next-state logic for sequencer and indicators.
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_req = mem_req_ff;
      nxt_we = mem_we_ff;
      nxt_addr = mem_addr_ff;
      nxt_wdata = mem_wdata_ff;
      nxt_busy = cur_ff.st != lmi_pkg::ST_IDLE;
      nxt_inv = 1'b0;
      nxt_start = 1'b0;
      nxt_ic = instr_counter_pair_ff;
      nxt_compat = compat_mode_bit_ff;
      nxt_cur.aux_we = 1'b0;
      nxt_cur.cs_meta = check_stop_sw;
      nxt_cur.cs_sync = cur_ff.cs_meta;
      // Decode of incoming instructions.
      if (instr_valid && cur_ff.st == lmi_pkg::ST_IDLE)
      begin
         nxt_cur.diag_en = instr_opcode == lmi_pkg::OP_DIAGNOSE; // see [RULE_16]
         if (instr_opcode == lmi_pkg::OP_INIT_MODE)
         begin
            if (!cur_ff.diag_en)
            begin
               nxt_inv = 1'b1; // see [RULE_01]
            end
            else
            begin
               nxt_cur.st = lmi_pkg::ST_COPY;
               nxt_cur.base = instr_operand_addr; // see [RULE_02]
               nxt_cur.method = load_method_field;
               nxt_cur.idx = '0;
               nxt_busy = 1'b1;
            end
         end
      end
      case (cur_ff.st)
         lmi_pkg::ST_IDLE:
         begin
         end
         lmi_pkg::ST_COPY:
         begin
            // One main storage read per byte, written to aux storage.
            if (mem_req_ff && mem_ack)
            begin
               nxt_req = 1'b0;
               nxt_cur.aux_we = 1'b1;
               nxt_cur.aux_waddr = cur_ff.idx[8:0];
               nxt_cur.aux_wdata = mem_rdata; // see [RULE_02]
               nxt_cur.idx = cur_ff.idx + 10'h001;
               if (cur_ff.idx == lmi_pkg::AUX_BYTES - 10'h001)
               begin
                  nxt_cur.st = lmi_pkg::ST_AUX_RD;
                  nxt_cur.idx = '0;
               end
            end
            else if (!mem_req_ff)
            begin
               nxt_req = 1'b1;
               nxt_we = 1'b0;
               nxt_addr = cur_ff.base + {6'h00, cur_ff.idx};
            end
         end
         lmi_pkg::ST_AUX_RD:
         begin
            // Address selected one cycle, data captured two cycles later.
            nxt_cur.idx = cur_ff.idx + 10'h001;
            case (cur_ff.idx[2:0])
               3'h0: nxt_cur.aux_raddr = lmi_pkg::AUX_IC_HI;
               3'h1: nxt_cur.aux_raddr = lmi_pkg::AUX_IC_LO;
               3'h2: nxt_cur.aux_raddr = lmi_pkg::AUX_BIAS_HI;
               3'h3: nxt_cur.aux_raddr = lmi_pkg::AUX_BIAS_LO;
               default: nxt_cur.aux_raddr = cur_ff.aux_raddr;
            endcase
            case (cur_ff.idx[2:0])
               3'h2: nxt_ic[15:8] = aux_rdata; // see [RULE_07]
               3'h3: nxt_ic[7:0] = aux_rdata; // see [RULE_07]
               3'h4: nxt_cur.bias[15:8] = aux_rdata;
               3'h5:
               begin
                  nxt_cur.bias[7:0] = aux_rdata;
                  nxt_cur.idx = lmi_pkg::POS_FIRST;
                  nxt_cur.st = card_load ? lmi_pkg::ST_CLEAR : lmi_pkg::ST_GUARD; // see [RULE_03]
               end
               default:
               begin
               end
            endcase
         end
         lmi_pkg::ST_CLEAR, lmi_pkg::ST_WMARK, lmi_pkg::ST_GUARD:
         begin
            // Storage writes, each held until acknowledged.
            if (mem_req_ff && mem_ack)
            begin
               nxt_req = 1'b0;
               if (cur_ff.st == lmi_pkg::ST_CLEAR)
               begin
                  nxt_cur.idx = cur_ff.idx + 10'h001;
                  if (cur_ff.idx == lmi_pkg::POS_LAST)
                  begin
                     nxt_cur.st = lmi_pkg::ST_WMARK;
                  end
               end
               else if (cur_ff.st == lmi_pkg::ST_WMARK)
               begin
                  nxt_cur.st = lmi_pkg::ST_GUARD;
               end
               else
               begin
                  nxt_cur.st = lmi_pkg::ST_FINISH;
               end
            end
            else if (!mem_req_ff)
            begin
               nxt_req = 1'b1;
               nxt_we = 1'b1;
               if (cur_ff.st == lmi_pkg::ST_CLEAR)
               begin
                  nxt_addr = cur_ff.bias + {6'h00, cur_ff.idx}; // see [RULE_04]
                  nxt_wdata = lmi_pkg::CH_BLANK;
               end
               else if (cur_ff.st == lmi_pkg::ST_WMARK)
               begin
                  nxt_addr = cur_ff.bias + {6'h00, lmi_pkg::POS_FIRST}; // see [RULE_04]
                  nxt_wdata = lmi_pkg::CH_BLANK_WM;
               end
               else
               begin
                  nxt_addr = cur_ff.bias - lmi_pkg::ONE16; // see [RULE_05]
                  nxt_wdata = lmi_pkg::CH_GUARD;
               end
            end
         end
         lmi_pkg::ST_FINISH:
         begin
            nxt_compat = 1'b1; // see [RULE_06]
            nxt_start = 1'b1; // see [RULE_07]
            nxt_cur.st = lmi_pkg::ST_IDLE;
         end
         default: nxt_cur.st = lmi_pkg::ST_IDLE;
      endcase
      if (sys_reset)
      begin
         nxt_compat = 1'b0; // see [RULE_15]
      end
      // Indicators; a set in the same cycle as a clear wins.
      nxt_wrap = (compat_mode_bit_ff && addr_past_size && (addr_access || addr_store_sar)) ||
                 (wrap_ind_ff && !wrap_clear); // see [RULE_08]
      nxt_last = last_card_evt || (last_card_ind_ff && !start_reset && !read_instr); // see [RULE_09]
      nxt_ch9 = ch9_sense || (ch9_ind_ff && !printer_cmd); // see [RULE_10]
      nxt_ch12 = ch12_sense || (ch12_ind_ff && !printer_cmd); // see [RULE_10]
      nxt_cur.eof_armed = nxt_armed;
      nxt_eof = tape_write && cur_ff.eof_armed[tape_unit]; // see [RULE_11]
      nxt_terr = (tape_err_evt && !(tape_mark_read && tape_odd_redund)) ||
                 (tape_err_ind_ff && !tape_err_clear); // see [RULE_12]
      // Reader error is held until the card ends when check-stop is on.
      nxt_halt = rdr2_card_end && (cur_ff.err_seen || (rdr2_read_err && cur_ff.cs_sync)); // see [RULE_13]
      if (rdr2_card_end)
      begin
         nxt_cur.err_seen = 1'b0;
      end
      else if (rdr2_read_err && cur_ff.cs_sync)
      begin
         nxt_cur.err_seen = 1'b1; // see [RULE_13]
      end
      nxt_cbs = cb_valid;
      nxt_cbc = cb_char;
      if (cb_mode && !cb_char_legal && cb_pos >= lmi_pkg::POS_FIRST && cb_pos <= lmi_pkg::POS_LAST)
      begin
         nxt_cbc = lmi_pkg::CH_BLANK; // see [RULE_14]
      end
   end

   // ==========================================================
   // State registers.
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cur_ff <= '0;
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= '0;
         mem_wdata_ff <= '0;
         init_busy_ff <= 1'b0;
         invalid_op_ff <= 1'b0;
         start_exec_ff <= 1'b0;
         instr_counter_pair_ff <= '0;
         compat_mode_bit_ff <= 1'b0; // see [RULE_15]
         wrap_ind_ff <= 1'b0;
         last_card_ind_ff <= 1'b0;
         ch9_ind_ff <= 1'b0;
         ch12_ind_ff <= 1'b0;
         tape_eof_ind_ff <= 1'b0;
         tape_err_ind_ff <= 1'b0;
         rdr2_halt_ff <= 1'b0;
         cb_store_ff <= 1'b0;
         cb_char_out_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
         mem_req_ff <= nxt_req;
         mem_we_ff <= nxt_we;
         mem_addr_ff <= nxt_addr;
         mem_wdata_ff <= nxt_wdata;
         init_busy_ff <= nxt_busy;
         invalid_op_ff <= nxt_inv;
         start_exec_ff <= nxt_start;
         instr_counter_pair_ff <= nxt_ic;
         compat_mode_bit_ff <= nxt_compat;
         wrap_ind_ff <= nxt_wrap;
         last_card_ind_ff <= nxt_last;
         ch9_ind_ff <= nxt_ch9;
         ch12_ind_ff <= nxt_ch12;
         tape_eof_ind_ff <= nxt_eof;
         tape_err_ind_ff <= nxt_terr;
         rdr2_halt_ff <= nxt_halt;
         cb_store_ff <= nxt_cbs;
         cb_char_out_ff <= nxt_cbc;
      end
   end
endmodule

// >>> tb/lmi_core_props.sv
`timescale 1ns/10ps
module lmi_core_props
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sys_reset,
   input wire logic instr_valid,
   input wire logic [7:0] instr_opcode,
   input wire logic [15:0] instr_operand_addr,
   input wire logic mem_req_ff,
   input wire logic mem_we_ff,
   input wire logic [15:0] mem_addr_ff,
   input wire logic init_busy_ff,
   input wire logic invalid_op_ff,
   input wire logic start_exec_ff,
   input wire logic compat_mode_bit_ff,
   input wire logic addr_past_size,
   input wire logic addr_access,
   input wire logic addr_store_sar,
   input wire logic wrap_ind_ff,
   input wire logic ch9_sense,
   input wire logic ch12_sense,
   input wire logic printer_cmd,
   input wire logic ch9_ind_ff,
   input wire logic ch12_ind_ff,
   input wire logic tape_err_evt,
   input wire logic tape_mark_read,
   input wire logic tape_odd_redund,
   input wire logic tape_err_ind_ff,
   input wire logic rdr2_card_end,
   input wire logic rdr2_halt_ff
);
   // ==========================================================
   // Helper state
   // Remembers whether the last taken instruction was the enabling diagnose.
   logic diag_ff;
   logic take_init;
   logic wrap_hit;
   assign take_init = instr_valid && !init_busy_ff && instr_opcode == lmi_pkg::OP_INIT_MODE;
   assign wrap_hit = compat_mode_bit_ff && addr_past_size && (addr_access || addr_store_sar);
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         diag_ff <= 1'b0;
      else if (instr_valid && !init_busy_ff)
         diag_ff <= (instr_opcode == lmi_pkg::OP_DIAGNOSE);
   end
   // ==========================================================
   // Properties
   default clocking dck @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   chk_init_refuse: assert property (take_init |=> invalid_op_ff == !$past(diag_ff))
      else $error("initialize opcode gating wrong");
   chk_copy_start: assert property ((take_init && diag_ff) |=>
      init_busy_ff ##1 (mem_req_ff && !mem_we_ff && mem_addr_ff == $past(instr_operand_addr, 2)))
      else $error("copy does not start at operand");
   chk_mode_clear: assert property (sys_reset |=> !compat_mode_bit_ff)
      else $error("mode bit survives system reset");
   chk_mode_entry: assert property ($rose(compat_mode_bit_ff) |-> start_exec_ff)
      else $error("mode bit rose without start");
   chk_wrap_quiet: assert property ((!wrap_ind_ff && !wrap_hit) |=> !wrap_ind_ff)
      else $error("wrap flagged without access");
   chk_wrap_flag: assert property (wrap_hit |=> wrap_ind_ff)
      else $error("wrap not flagged on access");
   chk_chan_reset: assert property ((printer_cmd && !ch9_sense && !ch12_sense) |=>
      !ch9_ind_ff && !ch12_ind_ff)
      else $error("overflow indicators not cleared");
   chk_odd_mark: assert property ((tape_err_evt && tape_mark_read && tape_odd_redund &&
      !tape_err_ind_ff) |=> !tape_err_ind_ff)
      else $error("odd tape mark set tape error");
   chk_halt_cause: assert property (rdr2_halt_ff |-> $past(rdr2_card_end))
      else $error("halt not at card end");
   cover property (take_init && diag_ff);
   cover property (start_exec_ff);
   cover property (rdr2_halt_ff);
endmodule

// >>> tb/lmi_core_bench.sv
`timescale 1ns/10ps
module lmi_core_bench;
   logic clk_sys, resetn, instr_valid, mem_req_ff, mem_we_ff, mem_ack, init_busy_ff;
   logic invalid_op_ff, start_exec_ff, compat_mode_bit_ff, wrap_ind_ff, last_card_ind_ff;
   logic ch9_ind_ff, ch12_ind_ff, tape_eof_ind_ff, tape_err_ind_ff, rdr2_halt_ff, cb_store_ff;
   logic sys_reset, addr_past_size, addr_access, addr_store_sar, wrap_clear, last_card_evt;
   logic start_reset, read_instr, ch9_sense, ch12_sense, printer_cmd, tape_strip_evt;
   logic tape_write, tape_rewind, tape_backspace, tape_err_evt, tape_mark_read;
   logic tape_odd_redund, tape_err_clear, check_stop_sw, rdr2_read_err, rdr2_card_end;
   logic cb_mode, cb_valid, cb_char_legal;
   logic [2:0] tape_unit;
   logic [3:0] load_method_field;
   logic [7:0] instr_opcode, mem_wdata_ff, mem_rdata, cb_char, cb_char_out_ff;
   logic [9:0] cb_pos;
   logic [15:0] instr_operand_addr, mem_addr_ff, instr_counter_pair_ff, base, rd_n;
   logic [26:0] ev;
   logic [15:0] wa[$];
   logic [7:0] wd[$];
   int bad_count, samples_checked;
   // Event inputs are packed so one task can pulse any mix of them.
   assign {tape_unit, sys_reset, cb_char_legal, cb_mode, cb_valid, rdr2_card_end,
      rdr2_read_err, tape_err_clear, tape_odd_redund, tape_mark_read, tape_err_evt,
      tape_backspace, tape_rewind, tape_write, tape_strip_evt, printer_cmd, ch12_sense,
      ch9_sense, read_instr, start_reset, last_card_evt, wrap_clear, addr_store_sar,
      addr_access, addr_past_size} = ev;
   lmi_core u_dut (.*);
   // The clock toggles every half period of 4 ns.
   always #4 clk_sys = ~clk_sys;
   // ==========================================================
   // Helpers
   // Main storage byte pattern from address bits 10:0; values repeat across the copied block.
   function automatic logic [7:0] src(input logic [15:0] a);
      return a[7:0] + {a[10:8], 5'h00};
   endfunction
   task chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Raises the chosen events for one cycle; the tape unit stays selected.
   task pulse(input logic [26:0] m);
      @(posedge clk_sys);
      ev <= m;
      @(posedge clk_sys);
      ev <= {m[26:24], 24'h00_0000};
      #1;
   endtask
   // Presents one instruction for one cycle and checks the refusal pulse.
   task instr(input logic [7:0] op, input logic [3:0] m, input logic inv);
      @(posedge clk_sys);
      instr_valid <= 1'b1;
      instr_opcode <= op;
      instr_operand_addr <= base;
      load_method_field <= m;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1;
      chk_bit(invalid_op_ff, inv);
   endtask
   // Main storage acknowledges each request one cycle later and logs writes.
   always @(posedge clk_sys)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_ff && !mem_ack)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= src(mem_addr_ff);
         if (mem_we_ff)
         begin
            wa.push_back(mem_addr_ff);
            wd.push_back(mem_wdata_ff);
         end
         else
         begin
            chk_val(mem_addr_ff, base + rd_n);
            rd_n <= rd_n + 16'h0001;
         end
      end
   end
   // Runs one full initialization with the given load method.
   task run_init(input logic [3:0] m, input int nw);
      logic [15:0] bias;
      int n;
      bias = {src(base + {7'h00, lmi_pkg::AUX_BIAS_HI}), src(base + {7'h00, lmi_pkg::AUX_BIAS_LO})};
      n = 0;
      wa.delete();
      wd.delete();
      rd_n = 16'h0000;
      pulse(27'h080_0000);
      chk_bit(compat_mode_bit_ff, 1'b0);
      instr(lmi_pkg::OP_DIAGNOSE, m, 1'b0);
      instr(lmi_pkg::OP_INIT_MODE, m, 1'b0);
      chk_bit(init_busy_ff, 1'b1);
      while (start_exec_ff !== 1'b1 && n < 4000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk_bit(start_exec_ff, 1'b1);
      chk_bit(compat_mode_bit_ff, 1'b1);
      chk_val(instr_counter_pair_ff, {src(base + {7'h00, lmi_pkg::AUX_IC_HI}),
         src(base + {7'h00, lmi_pkg::AUX_IC_LO})});
      chk_val(rd_n, {6'h00, lmi_pkg::AUX_BYTES});
      chk_val(16'(wa.size()), 16'(nw));
      for (int i = 0; i < 80 && nw > 1; i++)
      begin
         chk_val(wa[i], bias + 16'(i + 1));
         chk_val({8'h00, wd[i]}, {8'h00, lmi_pkg::CH_BLANK});
      end
      if (nw > 1)
      begin
         chk_val(wa[80], bias + 16'h0001);
         chk_val({8'h00, wd[80]}, {8'h00, lmi_pkg::CH_BLANK_WM});
      end
      chk_val(wa[nw - 1], bias - 16'h0001);
      chk_val({8'h00, wd[nw - 1]}, {8'h00, lmi_pkg::CH_GUARD});
      @(posedge clk_sys);
      #1;
      chk_bit(init_busy_ff, 1'b0);
      $display("test init method %0d done", m);
   endtask
   // ==========================================================
   // Main sequence
   initial
   begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      {instr_valid, instr_opcode, instr_operand_addr, load_method_field} = '0;
      {ev, mem_ack, mem_rdata, rd_n, bad_count, samples_checked} = '0;
      check_stop_sw = 1'b1;
      cb_char = 8'h7f;
      cb_pos = 10'h005;
      base = 16'h1000;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      instr(lmi_pkg::OP_INIT_MODE, lmi_pkg::LM_NONE, 1'b1);
      instr(lmi_pkg::OP_DIAGNOSE, lmi_pkg::LM_NONE, 1'b0);
      instr(8'h47, lmi_pkg::LM_NONE, 1'b0);
      instr(lmi_pkg::OP_INIT_MODE, lmi_pkg::LM_NONE, 1'b1);
      $display("test opcode gating done");
      run_init(lmi_pkg::LM_CARD1, 82);
      base = 16'h2400;
      run_init(lmi_pkg::LM_CARD2, 82);
      base = 16'h3800;
      run_init(lmi_pkg::LM_TAPE, 1);
      run_init(lmi_pkg::LM_NONE, 1);
      pulse(27'h000_0001);
      chk_bit(wrap_ind_ff, 1'b0);
      pulse(27'h000_0003);
      chk_bit(wrap_ind_ff, 1'b1);
      pulse(27'h000_0008);
      chk_bit(wrap_ind_ff, 1'b0);
      pulse(27'h000_0005);
      chk_bit(wrap_ind_ff, 1'b1);
      pulse(27'h000_0010);
      pulse(27'h000_0040);
      chk_bit(last_card_ind_ff, 1'b0);
      pulse(27'h000_0010);
      chk_bit(last_card_ind_ff, 1'b1);
      pulse(27'h000_0020);
      chk_bit(last_card_ind_ff, 1'b0);
      pulse(27'h000_0180);
      pulse(27'h000_0080);
      chk_val({14'h0000, ch9_ind_ff, ch12_ind_ff}, 16'h0003);
      pulse(27'h000_0200);
      chk_val({14'h0000, ch9_ind_ff, ch12_ind_ff}, 16'h0000);
      pulse(27'h300_0800);
      chk_bit(tape_eof_ind_ff, 1'b0);
      pulse(27'h300_0400);
      pulse(27'h300_0800);
      chk_bit(tape_eof_ind_ff, 1'b1);
      pulse(27'h400_0800);
      chk_bit(tape_eof_ind_ff, 1'b0);
      pulse(27'h300_0800);
      chk_bit(tape_eof_ind_ff, 1'b1);
      pulse(27'h300_1000);
      pulse(27'h300_0800);
      chk_bit(tape_eof_ind_ff, 1'b0);
      pulse(27'h300_0400);
      pulse(27'h300_2000);
      pulse(27'h300_0800);
      chk_bit(tape_eof_ind_ff, 1'b0);
      pulse(27'h001_C000);
      chk_bit(tape_err_ind_ff, 1'b0);
      pulse(27'h000_C000);
      chk_bit(tape_err_ind_ff, 1'b1);
      pulse(27'h002_0000);
      chk_bit(tape_err_ind_ff, 1'b0);
      pulse(27'h004_0000);
      chk_bit(rdr2_halt_ff, 1'b0);
      pulse(27'h008_0000);
      chk_bit(rdr2_halt_ff, 1'b1);
      // With the switch off, a read error must not halt at card end.
      check_stop_sw <= 1'b0;
      repeat (2) @(posedge clk_sys);
      pulse(27'h004_0000);
      pulse(27'h008_0000);
      chk_bit(rdr2_halt_ff, 1'b0);
      pulse(27'h030_0000);
      chk_val({7'h00, cb_store_ff, cb_char_out_ff}, 16'h0140);
      pulse(27'h070_0000);
      chk_val({7'h00, cb_store_ff, cb_char_out_ff}, 16'h017f);
      $display("test indicators done");
      end_sim;
   end
   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      end_sim;
   end
endmodule
bind lmi_core lmi_core_props u_props (.*);
